// ===== common/tmcc_cfg.svh
/*
 * Constants of the timer common core: register offsets, field positions,
 * reset values and divider masks.
 * Assumes it is included by bare name and only holds definitions.
 */
`ifndef TMCC_CFG_SVH
`define TMCC_CFG_SVH

// Word offsets on the bus, byte addresses
`define TMCC_ADR_CTRL0 8'h00
`define TMCC_ADR_CTRL1 8'h04
`define TMCC_ADR_CNT_L 8'h08
`define TMCC_ADR_CNT_H 8'h0C
`define TMCC_ADR_CMPA_L 8'h10
`define TMCC_ADR_CMPA_H 8'h14
`define TMCC_ADR_CMPP_L 8'h18
`define TMCC_ADR_CMPP_H 8'h1C
`define TMCC_ADR_STATUS 8'h20
`define TMCC_ADR_MASK 8'h24

// Control byte 0 fields
`define TMCC_C0_PAUSE 7
`define TMCC_C0_SEL_HI 6
`define TMCC_C0_SEL_LO 4
`define TMCC_C0_ON 3
`define TMCC_C0_WMASK 8'hF8

// Control byte 1 fields
`define TMCC_C1_MODE_HI 7
`define TMCC_C1_MODE_LO 6
`define TMCC_C1_IO_HI 5
`define TMCC_C1_IO_LO 4
`define TMCC_C1_OC 3
`define TMCC_C1_CCLR 0
`define TMCC_C1_WMASK 8'hF9

// Status and mask bits
`define TMCC_ST_A 0
`define TMCC_ST_P 1

// Reset values
`define TMCC_RST_BYTE 8'h00
`define TMCC_RST_WORD 16'h0000
`define TMCC_RST_FLAGS 2'h0
`define TMCC_RST_DIV 6'h00

// Prescaler masks: tick when all masked bits are ones
`define TMCC_DIV4_MASK 6'h03
`define TMCC_DIV16_MASK 6'h0F
`define TMCC_DIV64_MASK 6'h3F

`endif

// ===== common/tmcc_pkg.sv
/*
 * Types of the timer common core: modes, clock selects, core types,
 * register pair selection and single pulse states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tmcc_pkg;

    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_SPO = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } tmcc_mode_t;

    typedef enum logic [2:0] {
        SEL_SYS4 = 3'h0,
        SEL_SYS = 3'h1,
        SEL_H16 = 3'h2,
        SEL_H64 = 3'h3,
        SEL_SUB = 3'h4,
        SEL_SUB2 = 3'h5,
        SEL_EXT_RISE = 3'h6,
        SEL_EXT_FALL = 3'h7
    } tmcc_clksel_t;

    typedef enum logic [1:0] {
        TYPE_COMPACT = 2'h0,
        TYPE_STANDARD = 2'h1,
        TYPE_PERIODIC = 2'h2
    } tmcc_type_t;

    typedef enum logic [1:0] {
        PAIR_CNT = 2'h0,
        PAIR_CMPA = 2'h1,
        PAIR_CMPP = 2'h2
    } tmcc_pair_t;

    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_PULSE = 3'b010,
        SP_DONE = 3'b100
    } tmcc_sp_t;

endpackage : tmcc_pkg

`default_nettype wire

// ===== common/tmcc_reg_if.sv
/*
 * Link between the timer core and its byte-buffered register pairs.
 * Assumes both ends run on the same clock; strobes last one cycle.
 */
`default_nettype none

interface tmcc_reg_if;
    import tmcc_pkg::*;
    logic wrLow;
    logic wrHigh;
    logic rdHigh;
    tmcc_pair_t pair;
    logic [7:0] wrByte;
    logic [7:0] cntLow;
    logic [15:0] cmpA;
    logic [15:0] cmpP;
    logic [7:0] bufByte;

    modport core (
        output wrLow, wrHigh, rdHigh, pair, wrByte, cntLow,
        input cmpA, cmpP, bufByte
    );
    modport regs (
        input wrLow, wrHigh, rdHigh, pair, wrByte, cntLow,
        output cmpA, cmpP, bufByte
    );
endinterface : tmcc_reg_if

`default_nettype wire

// ===== verilog/tmcc_pair_regs.sv
/*
 * Compare register pairs and the shared low byte buffer.
 * Assumes the core raises at most one strobe per cycle.
 */
`default_nettype none
`include "tmcc_cfg.svh"

module tmcc_pair_regs
    import tmcc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    tmcc_reg_if.regs bus
);

    logic [7:0] bufQ;
    logic [15:0] cmpAQ;
    logic [15:0] cmpPQ;

    assign bus.bufByte = bufQ;
    assign bus.cmpA = cmpAQ;
    assign bus.cmpP = cmpPQ;

    // Shared buffer: low writes land here, high reads snapshot into it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bufQ <= `TMCC_RST_BYTE;
        end else if (bus.wrLow) begin
            bufQ <= bus.wrByte;
        end else if (bus.rdHigh) begin
            case (bus.pair)
                PAIR_CNT: bufQ <= bus.cntLow;
                PAIR_CMPA: bufQ <= cmpAQ[7:0];
                PAIR_CMPP: bufQ <= cmpPQ[7:0];
                default: bufQ <= bufQ;
            endcase
        end
    end

    // Whole pair only changes on a high write, keeping both halves coherent
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmpAQ <= `TMCC_RST_WORD;
            cmpPQ <= `TMCC_RST_WORD;
        end else if (bus.wrHigh) begin
            if (bus.pair == PAIR_CMPA) begin
                cmpAQ <= {bus.wrByte, bufQ};
            end
            if (bus.pair == PAIR_CMPP) begin
                cmpPQ <= {bus.wrByte, bufQ};
            end
        end
    end

endmodule : tmcc_pair_regs

`default_nettype wire

// ===== verilog/tmcc_top.sv
/*
 * Timer common core: up-counter, comparators A and P, clock selection,
 * external clock/trigger input, one output pin, Wishbone register slave.
 * Assumes a classic Wishbone master on clk and asynchronous pin inputs.
 */
// How it works
// - Free-running up-counter compared continuously; equality is a match event.
// - A match raises an interrupt, may clear counter and change output.
// - Separate interrupt sources for comparator A and comparator P.
// - Three-bit select picks divided system, high, subsidiary or external clock.
// - With external clock selected, each active edge advances the counter.
// - External active edge is rising or falling per clock select.
// - Standard and periodic types use the external input as pulse trigger.
// - Compare output mode sets, clears or toggles the pin on match.
// - PWM waveform comes out on the same output pin.
// - High bytes are direct; low bytes pass through one shared buffer.
// - Buffer moves to or from low bytes only on high-byte access.
// - Low compare write only fills the buffer, live value unchanged.
// - High compare write stores high byte and commits buffered low byte.
// - High read returns high byte and snapshots live low byte.
// - Low read returns the buffer captured by the previous high read.
// - Three core types; compact lacks single pulse; PWM is edge aligned.
`default_nettype none
`include "tmcc_cfg.svh"

module tmcc_top
    import tmcc_pkg::*;
#(
    parameter tmcc_type_t TM_TYPE = TYPE_STANDARD
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timerExtClockIn,
    input wire logic subsidiaryClock,
    output logic timerOutputPin,
    output logic irqOut
);

    // Compact cores have no single pulse mode
    localparam logic HAS_SP = (TM_TYPE != TYPE_COMPACT);

    logic [7:0] ctrl0Q;
    logic [7:0] ctrl1Q;
    logic [15:0] cntQ;
    logic [15:0] cntNext;
    logic [1:0] statusQ;
    logic [1:0] maskQ;
    logic [1:0] w1c;
    logic ackQ;
    logic [31:0] datQ;
    logic [7:0] rdByte;
    logic irqQ;
    logic outQ;
    logic onPrevQ;
    logic [5:0] divQ;
    logic extMetaQ, extSyncQ, extLastQ;
    logic subMetaQ, subSyncQ, subLastQ;
    tmcc_sp_t spQ;
    logic busReq, wrReq, rdReq;
    logic tick, running, onRise, clearHit, matchA, matchP, spTrig, restart;
    logic extRise, extFall, subRise, pwmLevel;
    logic ctrOn, ctrPause, outInit, clrOnA;
    logic [1:0] ioSel;
    tmcc_clksel_t clkSel;
    tmcc_mode_t mode;

    tmcc_reg_if regBus();

    tmcc_pair_regs u_pairs (
        .clk(clk),
        .resetn(resetn),
        .bus(regBus.regs)
    );

    // Word match on the aligned address
    function automatic logic isAt(input logic [7:0] adr,
                                  input logic [7:0] off);
        isAt = (adr[7:2] == off[7:2]);
    endfunction : isAt

    // Prescaler tap: true once per wrap of the masked bits
    function automatic logic divTap(input logic [5:0] cnt,
                                    input logic [5:0] msk);
        divTap = ((cnt & msk) == msk);
    endfunction : divTap

    // Field decode
    assign ctrOn = ctrl0Q[`TMCC_C0_ON];
    assign ctrPause = ctrl0Q[`TMCC_C0_PAUSE];
    assign clkSel = tmcc_clksel_t'(ctrl0Q[`TMCC_C0_SEL_HI:`TMCC_C0_SEL_LO]);
    assign mode = tmcc_mode_t'(ctrl1Q[`TMCC_C1_MODE_HI:`TMCC_C1_MODE_LO]);
    assign ioSel = ctrl1Q[`TMCC_C1_IO_HI:`TMCC_C1_IO_LO];
    assign outInit = ctrl1Q[`TMCC_C1_OC];
    assign clrOnA = ctrl1Q[`TMCC_C1_CCLR];

    // Bus request, one answer per request
    assign busReq = wb_cyc_i && wb_stb_i && !ackQ;
    assign wrReq = busReq && wb_we_i && wb_sel_i[0];
    assign rdReq = busReq && !wb_we_i;

    // Pin inputs: two flops, then an edge register after the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            extMetaQ <= 1'b0;
            extSyncQ <= 1'b0;
            extLastQ <= 1'b0;
            subMetaQ <= 1'b0;
            subSyncQ <= 1'b0;
            subLastQ <= 1'b0;
        end else begin
            extMetaQ <= timerExtClockIn;
            extSyncQ <= extMetaQ;
            extLastQ <= extSyncQ;
            subMetaQ <= subsidiaryClock;
            subSyncQ <= subMetaQ;
            subLastQ <= subSyncQ;
        end
    end

    assign extRise = extSyncQ && !extLastQ;
    assign extFall = !extSyncQ && extLastQ;
    assign subRise = subSyncQ && !subLastQ;

    // Free prescaler; high clock is taken as the system clock here
    always_ff @(posedge clk) begin
        if (!resetn) begin
            divQ <= `TMCC_RST_DIV;
        end else begin
            divQ <= divQ + 6'h01;
        end
    end

    // Counting tick select
    always_comb begin
        case (clkSel)
            SEL_SYS4: tick = divTap(divQ, `TMCC_DIV4_MASK);
            SEL_SYS: tick = 1'b1;
            SEL_H16: tick = divTap(divQ, `TMCC_DIV16_MASK);
            SEL_H64: tick = divTap(divQ, `TMCC_DIV64_MASK);
            SEL_SUB: tick = subRise;
            SEL_SUB2: tick = subRise;
            SEL_EXT_RISE: tick = extRise;
            SEL_EXT_FALL: tick = extFall;
            default: tick = 1'b0;
        endcase
    end

    // Single pulse trigger on the selected edge of the external input
    assign spTrig = HAS_SP && ctrOn && (mode == MODE_SPO) &&
                    (clkSel[0] ? extFall : extRise);
    assign onRise = ctrOn && !onPrevQ;
    assign restart = onRise || (spTrig && spQ != SP_PULSE); // No stale match
    // In single pulse mode the counter only runs during the pulse
    assign running = ctrOn && !ctrPause && !restart &&
                     (mode != MODE_SPO || !HAS_SP || spQ == SP_PULSE);
    assign clearHit = clrOnA ? (cntQ == regBus.cmpA)
                             : (cntQ == regBus.cmpP);
    assign cntNext = clearHit ? `TMCC_RST_WORD : cntQ + 16'h0001;
    // Event when the counter steps onto a compare value
    assign matchA = running && tick && (cntNext == regBus.cmpA);
    assign matchP = running && tick && (cntNext == regBus.cmpP);
    // Edge aligned: active from period start until A
    assign pwmLevel = (cntQ < regBus.cmpA) ? outInit : !outInit;

    // Counter; switch-on, or a trigger outside the pulse, restarts from zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cntQ <= `TMCC_RST_WORD;
            onPrevQ <= 1'b0;
        end else begin
            onPrevQ <= ctrOn;
            if (restart) begin
                cntQ <= `TMCC_RST_WORD;
            end else if (running && tick) begin
                cntQ <= cntNext;
            end
        end
    end

    // Single pulse sequencer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            spQ <= SP_IDLE;
        end else begin
            case (spQ)
                SP_IDLE: if (spTrig) begin
                    spQ <= SP_PULSE;
                end
                SP_PULSE: if (!ctrOn) begin
                    spQ <= SP_IDLE;
                end else if (matchA) begin
                    spQ <= SP_DONE;
                end
                SP_DONE: if (!ctrOn) begin
                    spQ <= SP_IDLE;
                end else if (spTrig) begin
                    spQ <= SP_PULSE;
                end
                default: spQ <= SP_IDLE;
            endcase
        end
    end

    // Output pin; timer mode leaves it alone
    always_ff @(posedge clk) begin
        if (!resetn) begin
            outQ <= 1'b0;
        end else if (onRise && mode != MODE_TMR) begin
            outQ <= outInit;
        end else if (ctrOn) begin
            case (mode)
                MODE_CMP: if (matchA) begin
                    case (ioSel)
                        2'h1: outQ <= 1'b0;
                        2'h2: outQ <= 1'b1;
                        2'h3: outQ <= !outQ;
                        default: outQ <= outQ;
                    endcase
                end
                MODE_PWM: begin
                    case (ioSel)
                        2'h0: outQ <= !outInit;
                        2'h1: outQ <= outInit;
                        2'h2: outQ <= pwmLevel;
                        default: outQ <= outQ;
                    endcase
                end
                MODE_SPO: if (spTrig && spQ != SP_PULSE) begin
                    outQ <= outInit;
                end else if (matchA && spQ == SP_PULSE) begin
                    outQ <= !outInit;
                end
                default: outQ <= outQ;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl0Q <= `TMCC_RST_BYTE;
            ctrl1Q <= `TMCC_RST_BYTE;
            maskQ <= `TMCC_RST_FLAGS;
        end else if (wrReq) begin
            if (isAt(wb_adr_i, `TMCC_ADR_CTRL0)) begin
                ctrl0Q <= wb_dat_i[7:0] & `TMCC_C0_WMASK;
            end
            if (isAt(wb_adr_i, `TMCC_ADR_CTRL1)) begin
                ctrl1Q <= wb_dat_i[7:0] & `TMCC_C1_WMASK;
            end
            if (isAt(wb_adr_i, `TMCC_ADR_MASK)) begin
                maskQ <= wb_dat_i[1:0];
            end
        end
    end

    // Sticky flags; a new event beats a same-cycle clear
    assign w1c = (wrReq && isAt(wb_adr_i, `TMCC_ADR_STATUS)) ?
                 wb_dat_i[1:0] : 2'h0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            statusQ <= `TMCC_RST_FLAGS;
            irqQ <= 1'b0;
        end else begin
            statusQ <= (statusQ & ~w1c) | {matchP, matchA};
            irqQ <= |(statusQ & maskQ);
        end
    end

    // Strobes to the pair registers
    always_comb begin
        regBus.pair = PAIR_CNT;
        if (isAt(wb_adr_i, `TMCC_ADR_CMPA_L) ||
            isAt(wb_adr_i, `TMCC_ADR_CMPA_H)) begin
            regBus.pair = PAIR_CMPA;
        end else if (isAt(wb_adr_i, `TMCC_ADR_CMPP_L) ||
                     isAt(wb_adr_i, `TMCC_ADR_CMPP_H)) begin
            regBus.pair = PAIR_CMPP;
        end
    end

    // Counter pair is read only, so its low address never loads the buffer
    assign regBus.wrLow = wrReq && (isAt(wb_adr_i, `TMCC_ADR_CMPA_L) ||
                          isAt(wb_adr_i, `TMCC_ADR_CMPP_L));
    assign regBus.wrHigh = wrReq && (isAt(wb_adr_i, `TMCC_ADR_CMPA_H) ||
                           isAt(wb_adr_i, `TMCC_ADR_CMPP_H));
    assign regBus.rdHigh = rdReq && (isAt(wb_adr_i, `TMCC_ADR_CNT_H) ||
                           isAt(wb_adr_i, `TMCC_ADR_CMPA_H) ||
                           isAt(wb_adr_i, `TMCC_ADR_CMPP_H));
    assign regBus.wrByte = wb_dat_i[7:0];
    assign regBus.cntLow = cntQ[7:0];

    // Read mux; low addresses show the buffer, not live bytes
    always_comb begin
        rdByte = 8'h00;
        if (isAt(wb_adr_i, `TMCC_ADR_CTRL0)) begin
            rdByte = ctrl0Q;
        end else if (isAt(wb_adr_i, `TMCC_ADR_CTRL1)) begin
            rdByte = ctrl1Q;
        end else if (isAt(wb_adr_i, `TMCC_ADR_CNT_L) ||
                     isAt(wb_adr_i, `TMCC_ADR_CMPA_L) ||
                     isAt(wb_adr_i, `TMCC_ADR_CMPP_L)) begin
            rdByte = regBus.bufByte;
        end else if (isAt(wb_adr_i, `TMCC_ADR_CNT_H)) begin
            rdByte = cntQ[15:8];
        end else if (isAt(wb_adr_i, `TMCC_ADR_CMPA_H)) begin
            rdByte = regBus.cmpA[15:8];
        end else if (isAt(wb_adr_i, `TMCC_ADR_CMPP_H)) begin
            rdByte = regBus.cmpP[15:8];
        end else if (isAt(wb_adr_i, `TMCC_ADR_STATUS)) begin
            rdByte = {6'h00, statusQ};
        end else if (isAt(wb_adr_i, `TMCC_ADR_MASK)) begin
            rdByte = {6'h00, maskQ};
        end
    end

    // Registered answer one cycle after the request; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ackQ <= 1'b0;
            datQ <= 32'h0000_0000;
        end else begin
            ackQ <= busReq;
            if (rdReq) begin
                datQ <= {{24{1'b0}}, rdByte};
            end
        end
    end

    assign wb_ack_o = ackQ;
    assign wb_dat_o = datQ;
    assign timerOutputPin = outQ;
    assign irqOut = irqQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence sHighRead;
        rdReq && isAt(wb_adr_i, `TMCC_ADR_CNT_H);
    endsequence

    sequence sLowRead;
        rdReq && isAt(wb_adr_i, `TMCC_ADR_CNT_L);
    endsequence

    a_count_step: assert property (
        running && tick && !clearHit && !onRise && !spTrig |=>
        cntQ == $past(cntQ) + 16'h0001)
        else $error("counter did not step");

    a_clear_match: assert property (
        running && tick && clearHit && !onRise |=> cntQ == 16'h0000)
        else $error("counter not cleared on match");

    a_irq_flags: assert property (
        matchA || matchP |=>
        (statusQ & {$past(matchP), $past(matchA)}) ==
        {$past(matchP), $past(matchA)}
        ##1 irqQ == |($past(statusQ) & $past(maskQ)))
        else $error("match flags or interrupt wrong");

    a_ext_edge: assert property (
        clkSel == SEL_EXT_FALL |-> tick == (!extSyncQ && extLastQ))
        else $error("external edge select wrong");

    a_cmp_set_high: assert property (
        ctrOn && !onRise && mode == MODE_CMP && ioSel == 2'h2 && matchA
        |=> timerOutputPin)
        else $error("output not driven high on match");

    a_pwm_pin: assert property (
        ctrOn && !onRise && mode == MODE_PWM && ioSel == 2'h2
        |=> timerOutputPin == $past(pwmLevel))
        else $error("pwm level wrong");

    a_low_buffered: assert property (
        regBus.wrLow |=> $stable(regBus.cmpA) && $stable(regBus.cmpP))
        else $error("low write reached compare value");

    a_high_commit: assert property (
        regBus.wrHigh && regBus.pair == PAIR_CMPA |=>
        regBus.cmpA == {$past(wb_dat_i[7:0]), $past(regBus.bufByte)})
        else $error("high write did not commit pair");

    a_snap_read: assert property (
        sHighRead ##1 (!regBus.wrLow && !regBus.rdHigh) [*3] ##0 sLowRead
        |=> wb_dat_o[7:0] == $past(cntQ[7:0], 4))
        else $error("low read not from snapshot");

    a_no_sp_compact: assert property (
        !HAS_SP |-> spQ == SP_IDLE)
        else $error("compact core entered single pulse");

endmodule : tmcc_top

`default_nettype wire

// ===== test/tmcc_top_test.sv
/*
 * Self-checking bench of the timer core: register pairs through the
 * shared buffer, compare A and P events, external edges and PWM.
 * Assumes the Wishbone slave answers as tmcc_top is described.
 */
`default_nettype none
`include "tmcc_cfg.svh"

module tmcc_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tmcc_pkg::*;

    logic clk;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic timerExtClockIn = 1'b0;
    logic subsidiaryClock = 1'b0;
    logic timerOutputPin;
    logic irqOut;
    logic [7:0] rd;
    int mismatches = 0;
    int comparisons = 0;
    int highs;

    tmcc_top #(.TM_TYPE(TYPE_STANDARD)) u_tmcc_top (
        .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .timerExtClockIn(timerExtClockIn),
        .subsidiaryClock(subsidiaryClock),
        .timerOutputPin(timerOutputPin), .irqOut(irqOut)
    );

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task end_sim;
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task check(input string name, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Held until ack is sampled, then one idle cycle before the next
    task wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask : wb_xfer

    task wr(input logic [7:0] a, input logic [7:0] d);
        wb_xfer(1'b1, a, d);
    endtask : wr

    task rcheck(input string name, input logic [7:0] a, input logic [7:0] e);
        wb_xfer(1'b0, a, 8'h00);
        check(name, {8'h00, rd}, {8'h00, e});
    endtask : rcheck

    // Slow pulses so the pin synchroniser sees both edges
    task pulses(input int n);
        repeat (n) begin
            timerExtClockIn <= 1'b1;
            repeat (5) @(posedge clk);
            timerExtClockIn <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask : pulses

    // Cuts a hang short well beyond the expected run
    initial begin
        #500000;
        mismatches++;
        end_sim;
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rcheck("cnt high", `TMCC_ADR_CNT_H, 8'h00);
        rcheck("cnt low", `TMCC_ADR_CNT_L, 8'h00);
        rcheck("cmpa high", `TMCC_ADR_CMPA_H, 8'h00);
        rcheck("status", `TMCC_ADR_STATUS, 8'h00);
        // Low write fills only the buffer; high read snapshots live low
        wr(`TMCC_ADR_CMPA_L, 8'h34);
        rcheck("cmpa high", `TMCC_ADR_CMPA_H, 8'h00);
        rcheck("cmpa low", `TMCC_ADR_CMPA_L, 8'h00);
        wr(`TMCC_ADR_CMPA_L, 8'h10);
        wr(`TMCC_ADR_CMPA_H, 8'h00);
        rcheck("cmpa high", `TMCC_ADR_CMPA_H, 8'h00);
        rcheck("cmpa low", `TMCC_ADR_CMPA_L, 8'h10);
        // Compare A sets the pin high and raises the A status bit
        wr(`TMCC_ADR_MASK, 8'h01);
        wr(`TMCC_ADR_CTRL1, 8'h21);
        wr(`TMCC_ADR_CTRL0, 8'h18);
        check("pin initial", timerOutputPin, 1'b0);
        repeat (40) @(posedge clk);
        check("pin set", timerOutputPin, 1'b1);
        check("irq", irqOut, 1'b1);
        wb_xfer(1'b0, `TMCC_ADR_STATUS, 8'h00);
        check("status a", rd[0], 1'b1);
        wr(`TMCC_ADR_MASK, 8'h00);
        repeat (3) @(posedge clk);
        check("irq masked", irqOut, 1'b0);
        wr(`TMCC_ADR_CTRL0, 8'h10);
        wr(`TMCC_ADR_STATUS, 8'h03);
        rcheck("status clear", `TMCC_ADR_STATUS, 8'h00);
        // Compare P alone, counter clears on P before A is reached
        wr(`TMCC_ADR_CMPP_L, 8'h08);
        wr(`TMCC_ADR_CMPP_H, 8'h00);
        wr(`TMCC_ADR_CTRL1, 8'hC0);
        wr(`TMCC_ADR_MASK, 8'h02);
        wr(`TMCC_ADR_CTRL0, 8'h18);
        repeat (30) @(posedge clk);
        rcheck("status p", `TMCC_ADR_STATUS, 8'h02);
        check("irq p", irqOut, 1'b1);
        // External rising edges, then falling edges, each counted once
        wr(`TMCC_ADR_CTRL0, 8'h00);
        wr(`TMCC_ADR_CTRL0, 8'h68);
        pulses(5);
        rcheck("ext cnt high", `TMCC_ADR_CNT_H, 8'h00);
        rcheck("ext cnt low", `TMCC_ADR_CNT_L, 8'h05);
        wr(`TMCC_ADR_CTRL0, 8'h00);
        wr(`TMCC_ADR_CTRL0, 8'h78);
        pulses(3);
        rcheck("ext cnt high", `TMCC_ADR_CNT_H, 8'h00);
        rcheck("fall cnt low", `TMCC_ADR_CNT_L, 8'h03);
        // PWM active high while counter below A, period 17 ticks
        wr(`TMCC_ADR_CTRL0, 8'h00);
        wr(`TMCC_ADR_CTRL1, 8'hA9);
        wr(`TMCC_ADR_CTRL0, 8'h18);
        repeat (20) @(posedge clk);
        highs = 0;
        repeat (34) begin
            @(posedge clk);
            if (timerOutputPin === 1'b1) highs++;
        end
        check("pwm highs", highs[15:0], 16'h0020);
        // Single pulse: falling trigger runs the counter until A, then stops
        wr(`TMCC_ADR_CTRL0, 8'h00);
        wr(`TMCC_ADR_CTRL1, 8'h49);
        wr(`TMCC_ADR_CTRL0, 8'h18);
        check("sp armed", timerOutputPin, 1'b1);
        pulses(1);
        check("sp during", timerOutputPin, 1'b1);
        repeat (30) @(posedge clk);
        check("sp end", timerOutputPin, 1'b0);
        rcheck("sp cnt high", `TMCC_ADR_CNT_H, 8'h00);
        rcheck("sp cnt low", `TMCC_ADR_CNT_L, 8'h10);
        // Subsidiary clock: each rising edge is one count
        wr(`TMCC_ADR_CTRL0, 8'h00);
        wr(`TMCC_ADR_CTRL1, 8'hC0);
        wr(`TMCC_ADR_CTRL0, 8'h48);
        repeat (4) begin
            subsidiaryClock <= 1'b1;
            repeat (5) @(posedge clk);
            subsidiaryClock <= 1'b0;
            repeat (5) @(posedge clk);
        end
        rcheck("sub cnt high", `TMCC_ADR_CNT_H, 8'h00);
        rcheck("sub cnt low", `TMCC_ADR_CNT_L, 8'h04);
        rcheck("unmapped", 8'h30, 8'h00);
        check("dat upper", wb_dat_o[23:8], 16'h0000);
        end_sim;
    end
endmodule : tmcc_top_test

`default_nettype wire
